// file: hw/gpio_pin_interrupt_port.sv
// GPIO port with direction, set/clear data, GPIO interrupts, pin interrupt
// channels and function multiplexing. Assumes a classic Wishbone master on
// the same clock, and pins asynchronous to it; at most 32 pins.
// Operation
// - Each pin has its own direction bit: input or output.
// - Set and clear aliases change only pins written with one.
// - Per-pin mask lets each pin raise the GPIO interrupt.
// - Inputs interrupt from pin level; outputs only from software data.
// - Per-pin choice of level or edge detection.
// - Edge mode detects rising only or both edges.
// - Pin interrupt unit: edge or level with polarity inversion.
// - Pin interrupt detection ignores direction and pin owner.
// - Each channel takes up to 32 pins, one combined request.
// - Half ports of eight pins are assigned to channels.
// - Registers for assignment, mask, pending and clearing.
// - Pin states and latches readable whether masked or not.
// - Direction, data, pin mask, edge and inversion registers have write-one-set and write-one-clear aliases.
// - Each pin shared between GPIO and four peripheral functions.
module gpio_pin_interrupt_port import gpio_pkg::*; #(
  parameter int NPINS  = NPINS_DEF,
  parameter int NCH    = NCH_DEF,
  parameter int STAGES = SYNC_DEF
) (
  input  wire logic                   i_sys_clk,  // System clock, 50 MHz
  input  wire logic                   i_rst,      // Async reset, active high
  input  wire logic                   i_wb_cyc,   // Wishbone cycle
  input  wire logic                   i_wb_stb,   // Wishbone strobe
  input  wire logic                   i_wb_we,    // Wishbone write
  input  wire logic [31:0]            i_wb_adr,   // Byte address
  input  wire logic [3:0]             i_wb_sel,   // Byte enables
  input  wire logic [31:0]            i_wb_dat,   // Write data
  output logic      [31:0]            o_wb_dat,   // Read data
  output logic                        o_wb_ack,   // Acknowledge
  input  wire logic [NPINS-1:0]       i_pin,      // Pin input levels
  output logic      [NPINS-1:0]       o_pin_out,  // Pin output levels
  output logic      [NPINS-1:0]       o_pin_oe,   // Pin output enables
  input  wire logic [NFUNC*NPINS-1:0] i_func_out, // Peripheral outputs
  input  wire logic [NFUNC*NPINS-1:0] i_func_oe,  // Peripheral enables
  output logic      [NPINS-1:0]       o_func_in,  // Pins seen by peripherals
  output logic                        o_irq,      // GPIO interrupt, level
  output logic      [NCH-1:0]         o_pint_req  // Channel requests, level
);
  localparam int NHP = NPINS / HP_PINS;

  typedef struct packed {
    logic [NPINS-1:0] dir;
    logic [NPINS-1:0] dout;
    logic [NPINS-1:0] gmask;
    logic [NPINS-1:0] gsens;
    logic [NPINS-1:0] gboth;
    logic [NPINS-1:0] gstat;
    logic [NPINS-1:0] gprev;
    logic [31:0]      passign;
    logic [NPINS-1:0] pmask;
    logic [NPINS-1:0] pedge;
    logic [NPINS-1:0] pinv;
    logic [NPINS-1:0] platch;
    logic [NPINS-1:0] fen;
    logic [63:0]      fsel;
    logic             ack;
    logic [31:0]      rdat;
    logic [NPINS-1:0] pin_out;
    logic [NPINS-1:0] pin_oe;
    logic [NPINS-1:0] func_in;
    logic             irq;
    logic [NCH-1:0]   req;
  } port_state_t;

  port_state_t s_q, s_d;

  // ----------------------------------------------------------------
  // Pin synchroniser
  // ----------------------------------------------------------------
  pin_sync_if #(.N(NPINS)) sync_bus ();

  pin_sync #(.N(NPINS), .STAGES(STAGES)) u_sync (
    .i_sys_clk (i_sys_clk),
    .i_rst     (i_rst),
    .i_pin     (i_pin),
    .o_sync    (sync_bus)
  );

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Byte lanes expanded to a bit mask
  function automatic logic [31:0] lane_mask(input logic [3:0] sel);
    logic [31:0] m;
    m = '0;
    for (int b = 0; b < 4; b++) begin
      m[b*8 +: 8] = {8{sel[b]}};
    end
    return m;
  endfunction : lane_mask

  // Plain, set or clear update of a pin vector
  function automatic logic [NPINS-1:0] upd(input logic [NPINS-1:0] o,
                                           input logic [NPINS-1:0] d,
                                           input logic [NPINS-1:0] m,
                                           input logic [1:0]       k);
    logic [NPINS-1:0] r;
    r = o;
    case (k)
      WK_PLAIN: r = (o & ~m) | (d & m);
      WK_SET:   r = o | (d & m);
      WK_CLR:   r = o & ~(d & m);
      default:  r = o;
    endcase
    return r;
  endfunction : upd

  // ----------------------------------------------------------------
  // Bus strobes
  // ----------------------------------------------------------------
  // Write commits on the edge the master samples ack
  logic             req_v;
  logic             wen;
  logic [7:0]       adr;
  logic [31:0]      bm;
  logic [NPINS-1:0] wd;
  logic [NPINS-1:0] wm;
  logic [NPINS-1:0] gsrc;
  logic [NPINS-1:0] gset;
  logic [NPINS-1:0] pset;
  logic [NPINS-1:0] pend;

  assign req_v = i_wb_cyc & i_wb_stb;
  assign wen   = req_v & i_wb_we & s_q.ack;
  assign adr   = i_wb_adr[7:0];
  assign bm    = lane_mask(i_wb_sel);
  assign wd    = i_wb_dat[NPINS-1:0];
  assign wm    = bm[NPINS-1:0];
  assign pend  = s_q.platch & s_q.pmask;

  // ----------------------------------------------------------------
  // Event detection
  // ----------------------------------------------------------------
  // Outputs source from software data, inputs from the pin
  always_comb begin
    gsrc = (s_q.dir & s_q.dout) | (~s_q.dir & sync_bus.lvl);
    gset = '0;
    pset = '0;
    for (int i = 0; i < NPINS; i++) begin
      if (s_q.gsens[i]) begin
        gset[i] = (gsrc[i] & ~s_q.gprev[i]) |
                  (s_q.gboth[i] & ~gsrc[i] & s_q.gprev[i]);
      end else begin
        gset[i] = gsrc[i];
      end
      // Pin unit reads the synchronised pin, whatever drives it
      if (s_q.pedge[i]) begin
        pset[i] = s_q.pinv[i] ? sync_bus.fall[i] : sync_bus.rise[i];
      end else begin
        pset[i] = sync_bus.lvl[i] ^ s_q.pinv[i];
      end
    end
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  // Register writes, sticky flags, pin mux and channel requests
  always_comb begin
    s_d       = s_q;
    s_d.ack   = req_v & ~s_q.ack;
    s_d.gprev = gsrc;
    s_d.rdat  = RST_ZERO;
    if (wen) begin
      case (adr)
        A_DIR:       s_d.dir     = upd(s_q.dir, wd, wm, WK_PLAIN);
        A_DIR_SET:   s_d.dir     = upd(s_q.dir, wd, wm, WK_SET);
        A_DIR_CLR:   s_d.dir     = upd(s_q.dir, wd, wm, WK_CLR);
        A_DOUT:      s_d.dout    = upd(s_q.dout, wd, wm, WK_PLAIN);
        A_DOUT_SET:  s_d.dout    = upd(s_q.dout, wd, wm, WK_SET);
        A_DOUT_CLR:  s_d.dout    = upd(s_q.dout, wd, wm, WK_CLR);
        A_GMASK:     s_d.gmask   = upd(s_q.gmask, wd, wm, WK_PLAIN);
        A_GSENS:     s_d.gsens   = upd(s_q.gsens, wd, wm, WK_PLAIN);
        A_GBOTH:     s_d.gboth   = upd(s_q.gboth, wd, wm, WK_PLAIN);
        A_PASSIGN:   s_d.passign = (s_q.passign & ~bm) | (i_wb_dat & bm);
        A_PMASK:     s_d.pmask   = upd(s_q.pmask, wd, wm, WK_PLAIN);
        A_PMASK_SET: s_d.pmask   = upd(s_q.pmask, wd, wm, WK_SET);
        A_PMASK_CLR: s_d.pmask   = upd(s_q.pmask, wd, wm, WK_CLR);
        A_PEDGE:     s_d.pedge   = upd(s_q.pedge, wd, wm, WK_PLAIN);
        A_PEDGE_SET: s_d.pedge   = upd(s_q.pedge, wd, wm, WK_SET);
        A_PEDGE_CLR: s_d.pedge   = upd(s_q.pedge, wd, wm, WK_CLR);
        A_PINV:      s_d.pinv    = upd(s_q.pinv, wd, wm, WK_PLAIN);
        A_PINV_SET:  s_d.pinv    = upd(s_q.pinv, wd, wm, WK_SET);
        A_PINV_CLR:  s_d.pinv    = upd(s_q.pinv, wd, wm, WK_CLR);
        A_FEN:       s_d.fen     = upd(s_q.fen, wd, wm, WK_PLAIN);
        A_FSEL_LO:   s_d.fsel[31:0]  = (s_q.fsel[31:0] & ~bm) | (i_wb_dat & bm);
        A_FSEL_HI:   s_d.fsel[63:32] = (s_q.fsel[63:32] & ~bm) | (i_wb_dat & bm);
        default:     s_d.dir     = s_q.dir;
      endcase
    end
    // Write-one clear first, new events after: a set wins the same cycle
    s_d.gstat = s_q.gstat;
    s_d.platch = s_q.platch;
    if (wen && adr == A_GSTAT) begin
      s_d.gstat = upd(s_q.gstat, wd, wm, WK_CLR);
    end
    if (wen && adr == A_PLATCH) begin
      s_d.platch = upd(s_q.platch, wd, wm, WK_CLR);
    end
    s_d.gstat  = s_d.gstat | gset;
    s_d.platch = s_d.platch | pset;
    // Read data taken at the edge that raises ack
    if (req_v && !i_wb_we && !s_q.ack) begin
      case (adr)
        A_DIR:       s_d.rdat = 32'(s_q.dir);
        A_DOUT:      s_d.rdat = 32'(s_q.dout);
        A_PIN_IN:    s_d.rdat = 32'(sync_bus.lvl);
        A_GMASK:     s_d.rdat = 32'(s_q.gmask);
        A_GSENS:     s_d.rdat = 32'(s_q.gsens);
        A_GBOTH:     s_d.rdat = 32'(s_q.gboth);
        A_GSTAT:     s_d.rdat = 32'(s_q.gstat);
        A_PASSIGN:   s_d.rdat = s_q.passign;
        A_PMASK:     s_d.rdat = 32'(s_q.pmask);
        A_PEDGE:     s_d.rdat = 32'(s_q.pedge);
        A_PINV:      s_d.rdat = 32'(s_q.pinv);
        A_PLATCH:    s_d.rdat = 32'(s_q.platch);
        A_PREQ:      s_d.rdat = 32'(pend);
        A_PPIN:      s_d.rdat = 32'(sync_bus.lvl ^ s_q.pinv);
        A_FEN:       s_d.rdat = 32'(s_q.fen);
        A_FSEL_LO:   s_d.rdat = s_q.fsel[31:0];
        A_FSEL_HI:   s_d.rdat = s_q.fsel[63:32];
        default:     s_d.rdat = RST_ZERO;
      endcase
    end
    // Owner per pin: GPIO or one of four functions
    for (int i = 0; i < NPINS; i++) begin
      if (s_q.fen[i]) begin
        s_d.pin_out[i] = i_func_out[int'(s_q.fsel[2*i +: 2])*NPINS + i];
        s_d.pin_oe[i]  = i_func_oe[int'(s_q.fsel[2*i +: 2])*NPINS + i];
      end else begin
        s_d.pin_out[i] = s_q.dout[i];
        s_d.pin_oe[i]  = s_q.dir[i];
      end
    end
    s_d.func_in = sync_bus.lvl;
    s_d.irq     = |(s_q.gstat & s_q.gmask);
    // Each channel ORs pending pins of the half ports assigned to it
    s_d.req = '0;
    for (int c = 0; c < NCH; c++) begin
      for (int h = 0; h < NHP; h++) begin
        if (s_q.passign[h*8 + ASG_EN_BIT] &&
            int'(s_q.passign[h*8 +: ASG_CH_W]) == c) begin
          s_d.req[c] = s_d.req[c] | (|pend[h*HP_PINS +: HP_PINS]);
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign o_wb_dat   = s_q.rdat;
  assign o_wb_ack   = s_q.ack;
  assign o_pin_out  = s_q.pin_out;
  assign o_pin_oe   = s_q.pin_oe;
  assign o_func_in  = s_q.func_in;
  assign o_irq      = s_q.irq;
  assign o_pint_req = s_q.req;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  AST_ACK_PULSE: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    o_wb_ack |=> !o_wb_ack) else $error("ack held longer than one cycle");

  AST_DIR_OE: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (s_q.fen == '0) |=> (o_pin_oe == $past(s_q.dir)))
    else $error("gpio output enable does not follow direction");

  AST_DOUT_SET: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (wen && adr == A_DOUT_SET) |=> (s_q.dout == ($past(s_q.dout) | ($past(wd) & $past(wm)))))
    else $error("set alias changed unselected pins");

  AST_DOUT_CLR: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (wen && adr == A_DOUT_CLR) |=> (s_q.dout == ($past(s_q.dout) & ~($past(wd) & $past(wm)))))
    else $error("clear alias changed unselected pins");

  AST_IRQ_MASK: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    ((s_q.gstat & s_q.gmask) == '0) |=> !o_irq)
    else $error("interrupt raised with every status bit masked");

  AST_OUT_SOFT: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (s_q.dir[0] && $past(s_q.dir[0]) && s_q.gsens[0] && $stable(s_q.dout[0]) && !s_q.gstat[0])
    |=> !s_q.gstat[0]) else $error("output pin interrupted without software change");

  AST_RISE_ONLY: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (s_q.gsens[0] && !s_q.gboth[0] && s_q.gprev[0] && !gsrc[0] && !s_q.gstat[0])
    |=> !s_q.gstat[0]) else $error("falling edge flagged in rising-only mode");

  AST_LVL_LATCH: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (!s_q.pedge[0] && (sync_bus.lvl[0] ^ s_q.pinv[0])) |=> s_q.platch[0])
    else $error("active level not latched");

  AST_LATCH_HOLD: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (s_q.platch[0] && !(wen && adr == A_PLATCH && wd[0] && i_wb_sel[0])) |=> s_q.platch[0])
    else $error("latch dropped without software clear");

  AST_REQ_IDLE: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (pend == '0) |=> (o_pint_req == '0))
    else $error("channel request without latched unmasked pin");

  AST_RDAT_IDLE: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    !o_wb_ack |-> (o_wb_dat == '0))
    else $error("read data shown outside the acknowledge cycle");

  AST_PMASK_SET: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (wen && adr == A_PMASK_SET) |=> (s_q.pmask == ($past(s_q.pmask) | ($past(wd) & $past(wm)))))
    else $error("mask set alias changed unselected bits");

  AST_PMASK_CLR: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (wen && adr == A_PMASK_CLR) |=> (s_q.pmask == ($past(s_q.pmask) & ~($past(wd) & $past(wm)))))
    else $error("mask clear alias changed unselected bits");

  AST_LVL_STAT: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (!s_q.gsens[0] && gsrc[0]) |=> s_q.gstat[0])
    else $error("active level not flagged in level mode");

  AST_BOTH_FALL: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (s_q.gsens[0] && s_q.gboth[0] && s_q.gprev[0] && !gsrc[0]) |=> s_q.gstat[0])
    else $error("falling edge missed in both-edge mode");

  AST_HP_MAP: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (s_q.passign[ASG_EN_BIT] && (|pend[HP_PINS-1:0])) |=> o_pint_req[$past(s_q.passign[ASG_CH_W-1:0])])
    else $error("half port request missing on its channel");

  AST_FUNC_PIN: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    s_q.fen[4] |=> (o_pin_out[4] == $past(i_func_out[int'(s_q.fsel[9:8])*NPINS + 4])))
    else $error("pin output not taken from its selected function");
endmodule : gpio_pin_interrupt_port

// file: hw/gpio_pkg.sv
// Package of the GPIO port with pin interrupt unit: offsets, fields, resets.
// Assumes a 32-bit classic Wishbone register bus with byte addresses.
package gpio_pkg;
  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int          NPINS_DEF   = 32;           // Pins of the port
  localparam int          NCH_DEF     = 4;            // Pin interrupt channels
  localparam int          NFUNC       = 4;            // Peripheral functions per pin
  localparam int          HP_PINS     = 8;            // Pins in one half port
  localparam int          SYNC_DEF    = 2;            // Synchroniser stages
  localparam int          ASG_EN_BIT  = 7;            // Half-port enable in its byte
  localparam int          ASG_CH_W    = 2;            // Channel field width
  localparam logic [31:0] RST_ZERO    = 32'h0000_0000;
  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] A_DIR       = 8'h00;
  localparam logic [7:0] A_DIR_SET   = 8'h04;
  localparam logic [7:0] A_DIR_CLR   = 8'h08;
  localparam logic [7:0] A_DOUT      = 8'h0C;
  localparam logic [7:0] A_DOUT_SET  = 8'h10;
  localparam logic [7:0] A_DOUT_CLR  = 8'h14;
  localparam logic [7:0] A_PIN_IN    = 8'h18;
  localparam logic [7:0] A_GMASK     = 8'h1C;
  localparam logic [7:0] A_GSENS     = 8'h20;
  localparam logic [7:0] A_GBOTH     = 8'h24;
  localparam logic [7:0] A_GSTAT     = 8'h28;
  localparam logic [7:0] A_PASSIGN   = 8'h2C;
  localparam logic [7:0] A_PMASK     = 8'h30;
  localparam logic [7:0] A_PMASK_SET = 8'h34;
  localparam logic [7:0] A_PMASK_CLR = 8'h38;
  localparam logic [7:0] A_PEDGE     = 8'h3C;
  localparam logic [7:0] A_PEDGE_SET = 8'h40;
  localparam logic [7:0] A_PEDGE_CLR = 8'h44;
  localparam logic [7:0] A_PINV      = 8'h48;
  localparam logic [7:0] A_PINV_SET  = 8'h4C;
  localparam logic [7:0] A_PINV_CLR  = 8'h50;
  localparam logic [7:0] A_PLATCH    = 8'h54;
  localparam logic [7:0] A_PREQ      = 8'h58;
  localparam logic [7:0] A_PPIN      = 8'h5C;
  localparam logic [7:0] A_FEN       = 8'h60;
  localparam logic [7:0] A_FSEL_LO   = 8'h64;
  localparam logic [7:0] A_FSEL_HI   = 8'h68;
  // Write kinds
  localparam logic [1:0] WK_PLAIN = 2'h0;
  localparam logic [1:0] WK_SET   = 2'h1;
  localparam logic [1:0] WK_CLR   = 2'h2;
endpackage : gpio_pkg

// file: hw/pin_sync.sv
// Pin synchroniser with edge detection for every pin.
// Assumes pins are asynchronous to i_sys_clk.
module pin_sync import gpio_pkg::*; #(
  parameter int N      = NPINS_DEF,
  parameter int STAGES = SYNC_DEF
) (
  input  wire logic         i_sys_clk, // System clock
  input  wire logic         i_rst,     // Async reset, active high
  input  wire logic [N-1:0] i_pin,     // Raw pin levels
  pin_sync_if.src           o_sync     // Synchronised levels and edges
);
  typedef struct packed {
    logic [STAGES-1:0][N-1:0] stg;
    logic [N-1:0]             prev;
  } sync_state_t;
  sync_state_t s_q, s_d;

  // Shift chain; first stage feeds only the second
  always_comb begin
    s_d      = s_q;
    s_d.stg  = {s_q.stg[STAGES-2:0], i_pin};
    s_d.prev = s_q.stg[STAGES-1];
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // Edges compare two settled stages, never the first
  assign o_sync.lvl  = s_q.stg[STAGES-1];
  assign o_sync.rise = s_q.stg[STAGES-1] & ~s_q.prev;
  assign o_sync.fall = ~s_q.stg[STAGES-1] & s_q.prev;
endmodule : pin_sync

// file: hw/pin_sync_if.sv
// Interface carrying synchronised pin levels and their edges.
// Assumes one clock shared by producer and consumer.
interface pin_sync_if #(parameter int N = 32);
  logic [N-1:0] lvl;   // Synchronised level
  logic [N-1:0] rise;  // Rose this cycle
  logic [N-1:0] fall;  // Fell this cycle
  modport src (output lvl, output rise, output fall);
  modport dst (input lvl, input rise, input fall);
endinterface : pin_sync_if

// file: verif/pin_far_end.sv
// Far-side model: outside circuitry on the port pins.
// Assumes the bench picks the outside level of every pin.
module pin_far_end #(
  parameter int N = 32
) (
  input  wire logic [N-1:0] i_pin_out, // Port output levels
  input  wire logic [N-1:0] i_pin_oe,  // Port output enables
  input  wire logic [N-1:0] i_ext_val, // Level from outside
  output logic      [N-1:0] o_pin_lvl  // Resolved pin level
);
  // ----------------------------------------------------------------
  // Pin resolution
  // ----------------------------------------------------------------
  // Port wins where it drives, so an output loops back to detectors
  always_comb begin
    for (int i = 0; i < N; i++) begin
      o_pin_lvl[i] = i_pin_oe[i] ? i_pin_out[i] : i_ext_val[i];
    end
  end
endmodule : pin_far_end

// file: verif/tb_gpio_pin_interrupt_port.sv
// Self-checking bench of the GPIO port with pin interrupt channels.
// Assumes the far-end pin model, one 50 MHz clock, Wishbone registers.
module tb_gpio_pin_interrupt_port import gpio_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------------
  // Signals and model state
  // ----------------------------------------------------------------
  logic         clk, rst, cyc, stb, we, ack, irq;
  logic [31:0]  adr, wdat, rdat, ext, pin_lvl, pin_out, pin_oe, func_in, seed, q;
  logic [3:0]   sel, preq;
  logic [127:0] func_out, func_oe;
  int           errors, samples_checked;
  logic [31:0]  m [logic [7:0]]; // Storage registers as software sees them
  logic [7:0]   stor [12] = '{A_DIR, A_DOUT, A_GMASK, A_GSENS, A_GBOTH, A_PASSIGN,
                              A_PMASK, A_PEDGE, A_PINV, A_FEN, A_FSEL_LO, A_FSEL_HI};
  logic [7:0]   bases [5] = '{A_DIR, A_DOUT, A_PMASK, A_PEDGE, A_PINV};

  gpio_pin_interrupt_port u_dut (
    .i_sys_clk(clk), .i_rst(rst), .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr),
    .i_wb_sel(sel), .i_wb_dat(wdat), .o_wb_dat(rdat), .o_wb_ack(ack), .i_pin(pin_lvl),
    .o_pin_out(pin_out), .o_pin_oe(pin_oe), .i_func_out(func_out), .i_func_oe(func_oe),
    .o_func_in(func_in), .o_irq(irq), .o_pint_req(preq));
  pin_far_end u_far (.i_pin_out(pin_out), .i_pin_oe(pin_oe), .i_ext_val(ext), .o_pin_lvl(pin_lvl));

  // Free-running system clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : lfsr

  // Model write; lanes without sel keep their old bits
  function automatic void mwr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    logic [31:0] bm;
    bm = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
    case (a)
      A_DIR_SET, A_DOUT_SET, A_PMASK_SET, A_PEDGE_SET, A_PINV_SET: m[a - 8'h04] |= d & bm;
      A_DIR_CLR, A_DOUT_CLR, A_PMASK_CLR, A_PEDGE_CLR, A_PINV_CLR: m[a - 8'h08] &= ~(d & bm);
      default: if (m.exists(a)) m[a] = (m[a] & ~bm) | (d & bm);
    endcase
  endfunction : mwr

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  // Classic cycle: hold everything until ack is sampled high
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    int n;
    n = 0;
    @(posedge clk);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= {24'h00_0000, a};
    wdat <= d;
    sel  <= s;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 50);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
    if (n >= 50) chk("wb_ack", 32'h0, 32'h1);
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s = 4'hf);
    bus(1'b1, a, d, s);
    mwr(a, d, s);
  endtask : wr

  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0000_0000, 4'hf);
    chk($sformatf("reg_%h", a), q, e);
  endtask : rdc

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick

  task automatic setp(input logic [31:0] v);
    @(posedge clk);
    ext <= v;
  endtask : setp

  task automatic conclude();
    $display("checks %0d errors %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : conclude
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    rst = 1'b1; cyc = 1'b0; stb = 1'b0; we = 1'b0; adr = '0; wdat = '0; sel = '0;
    ext = '0; func_out = '0; func_oe = '0; seed = 32'hb502_cce6; errors = 0; samples_checked = 0;
    foreach (stor[i]) m[stor[i]] = RST_ZERO;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    foreach (m[a]) rdc(a, m[a]);
    chk("oe", pin_oe, 32'h0);
    wr(8'h80, 32'hffff_ffff);
    rdc(8'h80, 32'h0);
    rdc(A_DIR_SET, 32'h0);
    // Random plain, set and clear writes; one round with partial byte lanes
    for (int i = 0; i < 9; i++) begin
      foreach (bases[j]) begin
        seed = lfsr(seed);
        wr(bases[j] + 8'(4 * (i % 3)), seed, (i == 4) ? 4'h5 : 4'hf);
        rdc(bases[j], m[bases[j]]);
      end
      chk("oe", pin_oe, m[A_DIR]);
      chk("out", pin_out, m[A_DOUT]);
    end
    foreach (bases[j]) wr(bases[j], 32'h0);
    tick(6);
    wr(A_GSTAT, 32'hffff_ffff);
    wr(A_PLATCH, 32'hffff_ffff);
    rdc(A_GSTAT, 32'h0);
    // GPIO edge interrupt, rising only, then both edges
    wr(A_GSENS, 32'h1);
    wr(A_GMASK, 32'h3);
    setp(32'h1);
    tick(6);
    rdc(A_GSTAT, 32'h1);
    chk("irq", irq, 1);
    rdc(A_PIN_IN, 32'h1);
    wr(A_GSTAT, 32'h1);
    setp(32'h0);
    tick(6);
    rdc(A_GSTAT, 32'h0);
    chk("irq", irq, 0);
    wr(A_GBOTH, 32'h1);
    setp(32'h1);
    tick(6);
    wr(A_GSTAT, 32'h1);
    setp(32'h0);
    tick(6);
    rdc(A_GSTAT, 32'h1);
    wr(A_GMASK, 32'h2);
    tick(2);
    chk("irq", irq, 0);
    rdc(A_GSTAT, 32'h1);
    wr(A_GSTAT, 32'h1);
    // Output pins interrupt from written data: pin 1 by level, pin 0 by both edges
    wr(A_DIR_SET, 32'h3);
    wr(A_DOUT_SET, 32'h3);
    tick(6);
    rdc(A_GSTAT, 32'h3);
    chk("irq", irq, 1);
    wr(A_DOUT_CLR, 32'h3);
    tick(6);
    rdc(A_GSTAT, 32'h3);
    wr(A_GSTAT, 32'h3);
    rdc(A_GSTAT, 32'h0);
    // Pin interrupt: inverted edge on pin 3, half port 0 to channel 2
    wr(A_DIR, 32'h0);
    wr(A_PEDGE_SET, 32'h8);
    wr(A_PINV_SET, 32'h8);
    wr(A_PASSIGN, 32'h0000_0082);
    wr(A_PMASK_SET, 32'h8);
    tick(6);
    wr(A_PLATCH, 32'hffff_ffff);
    setp(32'h8);
    tick(6);
    rdc(A_PLATCH, 32'h0);
    rdc(A_PPIN, 32'h0);
    chk("func_in", func_in, 32'h8);
    wr(A_DIR_SET, 32'h8); // Pin 3 now driven low by the port itself
    tick(6);
    rdc(A_PLATCH, 32'h8);
    rdc(A_PREQ, 32'h8);
    rdc(A_PPIN, 32'h8);
    chk("pint", {28'h000_0000, preq}, 32'h4);
    wr(A_PMASK_CLR, 32'h8);
    tick(2);
    chk("pint", {28'h000_0000, preq}, 32'h0);
    rdc(A_PLATCH, 32'h8);
    wr(A_PLATCH, 32'h8);
    rdc(A_PLATCH, 32'h0);
    // Every peripheral function takes over pin 4 in turn
    wr(A_FEN, 32'h10);
    for (int f = 0; f < 4; f++) begin
      seed = lfsr(seed);
      @(posedge clk);
      func_out <= {4{seed}};
      func_oe  <= {4{~seed}};
      wr(A_FSEL_LO, 32'(f) << 8);
      tick(2);
      chk("fout", {31'h0, pin_out[4]}, {31'h0, seed[4]});
      chk("foe", {31'h0, pin_oe[4]}, {31'h0, ~seed[4]});
      rdc(A_FSEL_LO, m[A_FSEL_LO]);
    end
    conclude();
  end

  // Watchdog well beyond the length of all scenarios
  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    conclude();
  end
endmodule : tb_gpio_pin_interrupt_port
